// file: src/csr_params.svh
// register offsets, field positions, reset values and timing counts for the slave serial channel
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH
// register byte offsets
`define CSR_OFF_DATA      8'h00
`define CSR_OFF_MODE      8'h04
`define CSR_OFF_CTRL      8'h08
`define CSR_OFF_TRIG      8'h0C
`define CSR_OFF_STAT      8'h10
`define CSR_OFF_FCLR      8'h14
`define CSR_OFF_OUTLVL    8'h18
`define CSR_OFF_OUTEN     8'h1C
`define CSR_OFF_PWR       8'h20
`define CSR_OFF_PRESC     8'h24
// mode register fields
`define CSR_MODE_ISS      0
// control register fields
`define CSR_CTRL_RXEN     0
`define CSR_CTRL_TXEN     1
`define CSR_CTRL_DAP      2
`define CSR_CTRL_CKP      3
`define CSR_CTRL_LSB      4
`define CSR_CTRL_LEN7     5
// trigger register fields
`define CSR_TRIG_START    0
`define CSR_TRIG_STOP     1
// status register fields
`define CSR_STAT_OVF      0
`define CSR_STAT_BFF      1
`define CSR_STAT_TSF      2
`define CSR_STAT_SE       3
// flag clear register fields
`define CSR_FCLR_OVF      0
// power register fields
`define CSR_PWR_U0        0
`define CSR_PWR_U1        1
// reset values
`define CSR_RST_CTRL      6'h03
`define CSR_RST_OUTLVL    1'b1
// timing: power-up settle time in system clocks
`define CSR_PWR_SETTLE    4
`endif

// file: src/csr_pkg.sv
// types shared by the slave serial channel
package csr_pkg;
  typedef enum logic [1:0] {
    CSR_ST_IDLE = 2'b01,
    CSR_ST_XFER = 2'b10
  } csr_state_t;
  typedef logic [7:0] csr_byte_t;
endpackage

// file: src/csr_slave_channel.sv
// slave-mode clocked serial channel with axi4-lite register access
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"
module csr_slave_channel
  import csr_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial pins
  input  wire logic        serial_clock_pin,
  input  wire logic        serial_in_pin,
  output var  logic        serial_out_pin,
  output var  logic        serial_out_oe,
  // interrupt
  output var  logic        channel_transfer_irq
);

  // register state
  logic [5:0]  ctrl_q;
  logic        iss_q;
  logic        outlvl_q;
  logic        outen_q;
  logic [1:0]  pwr_q;
  logic [7:0]  presc_q;
  logic        se_q;
  logic        ovf_q;
  logic        bff_q;
  logic        rx_full_q;
  csr_byte_t   tx_buf_q;
  csr_byte_t   rx_buf_q;
  csr_byte_t   shift_q;
  logic [3:0]  bitcnt_q;
  csr_state_t  state_q;
  logic        sck_s1_q;
  logic        sck_s2_q;
  logic        sck_prev_q;
  logic        sin_s1_q;
  logic        sin_s2_q;

  // axi handshake state
  logic        aw_got_q;
  logic        w_got_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // decoded control fields
  logic rx_en;
  logic tx_en;
  logic dap;
  logic lsb_first;
  logic [3:0] word_len;
  assign rx_en     = ctrl_q[`CSR_CTRL_RXEN];
  assign tx_en     = ctrl_q[`CSR_CTRL_TXEN];
  assign dap       = ctrl_q[`CSR_CTRL_DAP];
  assign lsb_first = ctrl_q[`CSR_CTRL_LSB];
  assign word_len  = ctrl_q[`CSR_CTRL_LEN7] ? 4'd7 : 4'd8;

  // two-flop synchronisers; the pin rate limit keeps edges apart
  // clock chain resets to the idle-high level so no false edge follows reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_s1_q   <= 1'b1;
      sck_s2_q   <= 1'b1;
      sck_prev_q <= 1'b1;
      sin_s1_q   <= 1'b0;
      sin_s2_q   <= 1'b0;
    end else begin
      sck_s1_q   <= serial_clock_pin;
      sck_s2_q   <= sck_s1_q;
      sck_prev_q <= sck_s2_q;
      sin_s1_q   <= serial_in_pin;
      sin_s2_q   <= sin_s1_q;
    end
  end

  // polarity-corrected clock edges from the master clock only
  logic sck_n;
  logic sck_p;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic shift_edge;
  assign sck_n      = sck_s2_q ^ ctrl_q[`CSR_CTRL_CKP];
  assign sck_p      = sck_prev_q ^ ctrl_q[`CSR_CTRL_CKP];
  assign lead_edge  = sck_p & ~sck_n;   // idle high, first falling
  assign trail_edge = ~sck_p & sck_n;
  // dap=1 shifts the sampling to the opposite edge, data leads by half
  assign sample_edge = dap ? lead_edge : trail_edge;
  assign shift_edge  = dap ? trail_edge : lead_edge;

  // axi write path decode
  logic wr_fire;
  logic [7:0] wr_addr;
  assign wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;
  assign wr_addr = awaddr_q;

  logic wr_data;
  logic wr_trig;
  logic wr_fclr;
  assign wr_data = wr_fire & (wr_addr == `CSR_OFF_DATA) & wstrb_q[0];
  assign wr_trig = wr_fire & (wr_addr == `CSR_OFF_TRIG) & wstrb_q[0];
  assign wr_fclr = wr_fire & (wr_addr == `CSR_OFF_FCLR) & wstrb_q[0];

  logic start_trig;
  logic stop_trig;
  assign start_trig = wr_trig & wdata_q[`CSR_TRIG_START];
  assign stop_trig  = wr_trig & wdata_q[`CSR_TRIG_STOP];

  // read of the data register consumes the received word unless a transmit word is pending
  logic rd_data;
  assign rd_data = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `CSR_OFF_DATA);

  // frame progress
  logic active;
  logic word_done;
  logic load_word;
  assign active    = (state_q == CSR_ST_XFER);
  assign word_done = active & sample_edge & (bitcnt_q == word_len - 4'd1);
  // a new word loads when idle with data ready, or back to back in continuous
  assign load_word = se_q & bff_q & tx_en & (!active | word_done);

  // axi write channel acceptance, address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_q      <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_q      <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        // unmapped offsets answer slverr
        s_axi_bresp  <= (wr_addr > `CSR_OFF_PRESC || wr_addr[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_got_q      <= 1'b0;
        w_got_q       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // configuration registers; guarded only by software discipline
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= `CSR_RST_CTRL;
      iss_q    <= 1'b0;
      outlvl_q <= `CSR_RST_OUTLVL;
      outen_q  <= 1'b0;
      pwr_q    <= 2'b00;
      presc_q  <= 8'h00;
    end else if (wr_fire && wstrb_q[0]) begin
      unique case (wr_addr)
        `CSR_OFF_CTRL:   ctrl_q   <= wdata_q[5:0];
        `CSR_OFF_MODE:   iss_q    <= wdata_q[`CSR_MODE_ISS];
        `CSR_OFF_OUTLVL: outlvl_q <= wdata_q[0];
        `CSR_OFF_OUTEN:  outen_q  <= wdata_q[0];
        `CSR_OFF_PWR:    pwr_q    <= wdata_q[1:0];
        `CSR_OFF_PRESC:  presc_q  <= wdata_q[7:0]; // no effect in slave mode
        default: ;
      endcase
    end
  end

  // channel enable: start sets, stop clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      se_q <= 1'b0;
    end else if (stop_trig) begin
      se_q <= 1'b0;
    end else if (start_trig) begin
      se_q <= 1'b1;
    end
  end

  // transmit buffer; a write while full simply overwrites
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf_q <= 8'h00;
      bff_q    <= 1'b0;
    end else if (wr_data) begin
      tx_buf_q <= wdata_q[7:0];
      bff_q    <= 1'b1;
    end else if (load_word || stop_trig) begin
      bff_q <= 1'b0;
    end
  end

  // shift engine with bit counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q  <= CSR_ST_IDLE;
      shift_q  <= 8'h00;
      bitcnt_q <= 4'd0;
    end else if (stop_trig || !se_q) begin
      state_q  <= CSR_ST_IDLE;
      bitcnt_q <= 4'd0;
    end else begin
      unique case (state_q)
        CSR_ST_IDLE: begin
          if (load_word) begin
            shift_q  <= tx_buf_q;
            bitcnt_q <= 4'd0;
            state_q  <= CSR_ST_XFER;
          end else if (!tx_en && rx_en) begin
            bitcnt_q <= 4'd0;
            state_q  <= CSR_ST_XFER;
          end
        end
        CSR_ST_XFER: begin
          if (sample_edge) begin
            // msb first shifts left, lsb first shifts right
            if (lsb_first) begin
              shift_q <= {sin_s2_q, shift_q[7:1]};
            end else begin
              shift_q <= {shift_q[6:0], sin_s2_q};
            end
            bitcnt_q <= bitcnt_q + 4'd1;
            if (word_done) begin
              bitcnt_q <= 4'd0;
              if (load_word) begin
                shift_q <= tx_buf_q;
              end else if (tx_en) begin
                state_q <= CSR_ST_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  // received word assembly, aligned for 7-bit words
  csr_byte_t rx_word;
  always_comb begin
    rx_word = 8'h00;
    if (lsb_first) begin
      rx_word = ctrl_q[`CSR_CTRL_LEN7] ? {1'b0, sin_s2_q, shift_q[7:2]}
                                       : {sin_s2_q, shift_q[7:1]};
    end else begin
      rx_word = ctrl_q[`CSR_CTRL_LEN7] ? {1'b0, shift_q[5:0], sin_s2_q}
                                       : {shift_q[6:0], sin_s2_q};
    end
  end

  // receive buffer and overrun; the new word wins over a same-cycle read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_q  <= 8'h00;
      rx_full_q <= 1'b0;
    end else if (word_done && rx_en) begin
      rx_buf_q  <= rx_word;
      rx_full_q <= 1'b1;
    end else if (rd_data && !bff_q) begin
      rx_full_q <= 1'b0;
    end
  end

  // overrun is the sole error; set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_q <= 1'b0;
    end else if (word_done && rx_en && rx_full_q && !(rd_data && !bff_q)) begin
      ovf_q <= 1'b1;
    end else if (wr_fclr && wdata_q[`CSR_FCLR_OVF]) begin
      ovf_q <= 1'b0;
    end
  end

  // serial output: shift msb or lsb; when stopped, held until an output level write
  logic out_bit;
  assign out_bit = lsb_first ? shift_q[0]
                 : (ctrl_q[`CSR_CTRL_LEN7] ? shift_q[6] : shift_q[7]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_out_pin <= `CSR_RST_OUTLVL;
      serial_out_oe  <= 1'b0;
    end else begin
      serial_out_oe <= outen_q & tx_en;
      if (!se_q) begin
        // stopped: pin only moves on an explicit output level write
        if (wr_fire && wr_addr == `CSR_OFF_OUTLVL) begin
          serial_out_pin <= wdata_q[0];
        end
      end else if (tx_en && active && (dap ? (bitcnt_q == 4'd0 && !sample_edge) : 1'b1)
                   && (shift_edge || (dap && bitcnt_q == 4'd0))) begin
        serial_out_pin <= out_bit;
      end else if (tx_en && active && sample_edge && !word_done) begin
        serial_out_pin <= lsb_first ? shift_q[1]
                        : (ctrl_q[`CSR_CTRL_LEN7] ? shift_q[5] : shift_q[6]);
      end
    end
  end

  // interrupt pulse: buffer-empty only with iss set and transmit enabled, else word done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_transfer_irq <= 1'b0;
    end else if (iss_q && tx_en) begin
      channel_transfer_irq <= load_word;
    end else begin
      channel_transfer_irq <= word_done;
    end
  end

  // axi read path; data reads the pending transmit word while full
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'b00;
      unique case (s_axi_araddr)
        `CSR_OFF_DATA:   s_axi_rdata <= {24'h0, bff_q ? tx_buf_q : rx_buf_q};
        `CSR_OFF_MODE:   s_axi_rdata <= {31'h0, iss_q};
        `CSR_OFF_CTRL:   s_axi_rdata <= {26'h0, ctrl_q};
        `CSR_OFF_STAT:   s_axi_rdata <= {28'h0, se_q, active, bff_q, ovf_q};
        `CSR_OFF_OUTLVL: s_axi_rdata <= {31'h0, outlvl_q};
        `CSR_OFF_OUTEN:  s_axi_rdata <= {31'h0, outen_q};
        `CSR_OFF_PWR:    s_axi_rdata <= {30'h0, pwr_q};
        `CSR_OFF_PRESC:  s_axi_rdata <= {24'h0, presc_q};
        `CSR_OFF_TRIG, `CSR_OFF_FCLR: s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: test/csr_master_model.sv
// behavioural serial master that clocks the slave channel
`timescale 1ns/1ps
`default_nettype none
module csr_master_model (
  // towards the slave
  output var logic serial_clock_pin,
  output var logic serial_in_pin,
  // from the slave
  input wire logic serial_out_pin
);
  initial begin
    serial_clock_pin = 1'b1;
    serial_in_pin = 1'b0;
  end
  // idle level only moved while the channel is stopped
  task automatic park(input logic ckp);
    serial_clock_pin <= !ckp;
  endtask
  // one word, first wire bit from tx[n-1]; hp in system clocks, 6 or more
  task automatic xfer(input logic [7:0] tx, input int n, input logic ckp,
                      input logic dap, input int hp, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      // pins move by non-blocking assignment so the edge they land on sees the old level
      serial_in_pin <= tx[i]; // held across both edges
      #(hp * 5);
      if (dap) rx[i] = serial_out_pin;
      serial_clock_pin <= ckp;
      #(hp * 5);
      if (!dap) rx[i] = serial_out_pin;
      serial_clock_pin <= !ckp;
      #(hp * 5);
    end
    serial_in_pin <= !serial_in_pin; // released line shows no stale bit
  endtask
endmodule
`default_nettype wire

// file: test/csr_slave_channel_properties.sv
// bus and pin checks for the slave serial channel
`timescale 1ns/1ps
`default_nettype none
module csr_slave_channel_properties (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // serial side
  input wire logic       serial_clock_pin,
  input wire logic       serial_out_pin,
  input wire logic       channel_transfer_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] sck_q;
  logic [3:0] wr_q;
  logic [7:0] aw_q;
  logic       sck_d1_q;
  // outside the map or unaligned is refused
  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a > 8'h24 || a[1:0] != 2'b00) ? 2'b10 : 2'b00;
  endfunction
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // cycles since the serial clock moved; saturates so long idles stay quiet
  always_ff @(posedge aclk) begin
    sck_d1_q <= serial_clock_pin;
    if (!aresetn || serial_clock_pin != sck_d1_q) sck_q <= 4'h0;
    else if (sck_q != 4'hF) sck_q <= sck_q + 4'h1;
  end
  // cycles since a write; a data load or level write may move the pin
  always_ff @(posedge aclk) begin
    if (!aresetn || (s_axi_wvalid && s_axi_wready)) wr_q <= 4'h0;
    else if (wr_q != 4'hF) wr_q <= wr_q + 4'h1;
  end
  // address of the write in flight
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
  end
  write_time_a: assert property (wr_taken_s |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  write_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == resp_of(aw_q))
    else $error("write answer code wrong");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  read_answer_a: assert property (rd_taken_s |=>
    s_axi_rvalid && s_axi_rresp == resp_of($past(s_axi_araddr))) else $error("read answer");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rresp)) else $error("read answer dropped");
  ready_low_a: assert property (wr_taken_s |=> !s_axi_awready && !s_axi_wready)
    else $error("ready while busy");
  irq_pulse_a: assert property ($rose(channel_transfer_irq) |=> !channel_transfer_irq)
    else $error("interrupt longer than one cycle");
  irq_cause_a: assert property (channel_transfer_irq |-> sck_q <= 4'h7 || wr_q <= 4'h7)
    else $error("interrupt without serial clock or load");
  out_hold_a: assert property (sck_q > 4'h7 && wr_q > 4'h7 |-> $stable(serial_out_pin))
    else $error("output moved while idle");
endmodule
bind csr_slave_channel csr_slave_channel_properties i_csr_slave_channel_properties (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .serial_clock_pin, .serial_out_pin, .channel_transfer_irq);
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the slave serial channel
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sck, sdi, sdo, oe, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [65:0] e;
  logic [65:0] rq[$];
  logic [1:0]  bq[$];
  logic [31:0] seed = 32'h3F953428;
  int          fails = 0, n_checks = 0, n_irq = 0;
  always #2.5 aclk = ~aclk;
  csr_slave_channel i_csr_slave_channel (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clock_pin(sck), .serial_in_pin(sdi), .serial_out_pin(sdo),
    .serial_out_oe(oe), .channel_transfer_irq(irq));
  csr_master_model i_csr_master_model (
    .serial_clock_pin(sck), .serial_in_pin(sdi), .serial_out_pin(sdo));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // wire image of a word for the set length and bit order
  function automatic logic [7:0] wire_of(input logic [7:0] v, input int n, input logic lsb);
    logic [7:0] o;
    o = 8'h00;
    for (int k = 0; k < n; k++) o[lsb ? n - 1 - k : k] = v[k];
    return o;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_done, w_done;
    @(posedge aclk);
    bq.push_back(r);
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      aw_done = aw_done | (awready === 1'b1);
      w_done = w_done | (wready === 1'b1);
      awvalid <= !aw_done;
      wvalid <= !w_done;
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    @(posedge aclk);
    rq.push_back({r, m, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  // stop, set up while disabled, restart
  task automatic setup(input logic [5:0] ctrl, input logic mode);
    logic lvl;
    wr(`CSR_OFF_TRIG, 32'h2, 2'b00);
    lvl = sdo;
    repeat (10) @(posedge aclk);
    chk({31'h0, sdo}, {31'h0, lvl});
    rd(`CSR_OFF_STAT, 32'h0, 32'h8, 2'b00);
    wr(`CSR_OFF_MODE, {31'h0, mode}, 2'b00);
    wr(`CSR_OFF_CTRL, {26'h0, ctrl}, 2'b00);
    i_csr_master_model.park(ctrl[3]);
    wr(`CSR_OFF_TRIG, 32'h1, 2'b00);
    rd(`CSR_OFF_STAT, 32'h8, 32'h8, 2'b00);
  endtask
  // cfg bits: data phase, clock polarity, lsb first, seven bits
  task automatic word(input logic [7:0] tx, input logic [7:0] rx, input logic [3:0] cfg,
                      input int hp);
    logic [7:0] got;
    int         n;
    n = cfg[3] ? 7 : 8;
    i_csr_master_model.xfer(wire_of(rx, n, cfg[2]), n, cfg[1], cfg[0], hp, got);
    repeat (8) @(posedge aclk);
    chk({24'h0, got}, {24'h0, wire_of(tx, n, cfg[2])});
  endtask
  // each answer against the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready && rq.size() > 0) begin
      e = rq.pop_front();
      chk(rdata & e[63:32], e[31:0] & e[63:32]);
      chk({30'h0, rresp}, {30'h0, e[65:64]});
    end
    if (bvalid === 1'b1 && bready && bq.size() > 0) chk({30'h0, bresp}, {30'h0, bq.pop_front()});
  end
  always @(posedge aclk) if (irq === 1'b1) n_irq++;
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
  initial begin
    logic [3:0] cfg;
    logic [7:0] a, b, c, r1, r2;
    int         base;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CSR_OFF_CTRL, 32'h03, 32'h3F, 2'b00);
    rd(`CSR_OFF_OUTLVL, 32'h1, 32'h1, 2'b00);
    rd(8'h28, 32'h0, 32'h0, 2'b10);
    wr(8'h2C, 32'h5, 2'b10);
    wr(`CSR_OFF_PWR, 32'h3, 2'b00);
    repeat (`CSR_PWR_SETTLE) @(posedge aclk);
    wr(`CSR_OFF_PRESC, 32'h5, 2'b00);
    rd(`CSR_OFF_PRESC, 32'h5, 32'hF, 2'b00);
    // a write without its low byte strobe must leave the register alone
    wstrb <= 4'h0;
    wr(`CSR_OFF_PRESC, 32'hA, 2'b00);
    wstrb <= 4'hF;
    rd(`CSR_OFF_PRESC, 32'h5, 32'hF, 2'b00);
    wr(`CSR_OFF_OUTEN, 32'h1, 2'b00);
    // each phase, polarity, order and length bit both ways over four settings, single transfers
    for (int i = 0; i < 4; i++) begin
      cfg = {i[0] ^ i[1], i[1], i[0], i[1]};
      setup({cfg, 2'b11}, 1'b0);
      a = rnd();
      r1 = rnd();
      base = n_irq;
      wr(`CSR_OFF_DATA, {24'h0, a}, 2'b00);
      word(a, r1, cfg, i[0] ? 6 : 12);
      rd(`CSR_OFF_DATA, {24'h0, r1}, cfg[3] ? 32'h7F : 32'hFF, 2'b00);
      chk(32'(n_irq - base), 32'h1);
      chk({31'h0, oe}, 32'h1);
    end
    // continuous: pending word read back and replaced, source switched late
    setup(6'h1F, 1'b1);
    {a, b, c, r1} = rnd();
    r2 = rnd();
    base = n_irq;
    wr(`CSR_OFF_DATA, {24'h0, a}, 2'b00);
    wr(`CSR_OFF_DATA, {24'h0, b}, 2'b00);
    rd(`CSR_OFF_STAT, 32'h2, 32'h2, 2'b00);
    rd(`CSR_OFF_DATA, {24'h0, b}, 32'hFF, 2'b00);
    wr(`CSR_OFF_DATA, {24'h0, c}, 2'b00);
    rd(`CSR_OFF_DATA, {24'h0, c}, 32'hFF, 2'b00);
    word(a, r1, 4'h7, 12);
    rd(`CSR_OFF_DATA, {24'h0, r1}, 32'hFF, 2'b00);
    wr(`CSR_OFF_MODE, 32'h0, 2'b00);
    word(c, r2, 4'h7, 6);
    rd(`CSR_OFF_STAT, 32'h0, 32'h4, 2'b00);
    rd(`CSR_OFF_DATA, {24'h0, r2}, 32'hFF, 2'b00);
    chk(32'(n_irq - base), 32'h3);
    // two words without a read, then clear the error
    wr(`CSR_OFF_DATA, {24'h0, a}, 2'b00);
    word(a, r1, 4'h7, 12);
    wr(`CSR_OFF_DATA, {24'h0, b}, 2'b00);
    word(b, r2, 4'h7, 12);
    rd(`CSR_OFF_STAT, 32'h1, 32'h1, 2'b00);
    wr(`CSR_OFF_FCLR, 32'h1, 2'b00);
    rd(`CSR_OFF_STAT, 32'h0, 32'h1, 2'b00);
    // receive only, buffer-empty source asked for anyway
    setup(6'h01, 1'b1);
    base = n_irq;
    i_csr_master_model.xfer(r1, 8, 1'b0, 1'b0, 12, a);
    repeat (8) @(posedge aclk);
    chk(32'(n_irq - base), 32'h1);
    chk({31'h0, oe}, 32'h0);
    rd(`CSR_OFF_DATA, {24'h0, r1}, 32'hFF, 2'b00);
    repeat (4) @(posedge aclk);
    give_verdict();
  end
endmodule
`default_nettype wire
